// File: verilog/frc_pkg.sv
// Purpose: shared constants for the free-running timer counter core
// Assumes: CPU clock drives clk_in; register accesses arrive as strobes
// Notes:   all values are counts or encodings, no addresses (no bus)
package frc_pkg;

  localparam int        COUNT_W        = 16;
  localparam int        BYTE_W         = 8;
  localparam logic [15:0] COUNT_RESET  = 16'hFFFC;
  localparam logic [15:0] COUNT_MAX    = 16'hFFFF;
  localparam logic [2:0]  PRESC_ONES   = 3'h7;

  // count clock select encodings
  localparam logic [1:0] SEL_DIV4  = 2'h0;
  localparam logic [1:0] SEL_DIV2  = 2'h1;
  localparam logic [1:0] SEL_DIV8  = 2'h2;
  localparam logic [1:0] SEL_EXT   = 2'h3;

  // prescaler masks: tick when the masked bits are all ones
  localparam logic [2:0] MASK_DIV2 = 3'h1;
  localparam logic [2:0] MASK_DIV4 = 3'h3;
  localparam logic [2:0] MASK_DIV8 = 3'h7;

  // external clock needs this many cpu clocks between active edges
  localparam int EXT_MIN_SPACING = 4;

  typedef enum logic [1:0] {
    RD_IDLE,
    RD_HELD
  } read_state_t;

endpackage

// File: verilog/ext_edge_detect.sv
// Purpose: detect the selected edge of the external count clock pin
// Assumes: pin is synchronous to clk_in; sampled on the falling edge
// Notes:   a missing pin must be tied high by the integrator
`timescale 1ns/1ps
module ext_edge_detect
  import frc_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic pin_in,
  input  wire logic rising_in,
  output logic      edge_out
);

  logic pin_reg;
  logic prev_reg;
  logic edge_next;

  // ---------------------------------------------------------------
  // falling-edge sampling
  // ---------------------------------------------------------------
  // pin sampled on the negative cpu edge; edge_out and the counts follow on the positive edge
  always_ff @(negedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_reg  <= 1'b1;
      prev_reg <= 1'b1;
    end else begin
      pin_reg  <= pin_in;
      prev_reg <= pin_reg;
    end
  end

  assign edge_next = rising_in ? (pin_reg & ~prev_reg)
                               : (~pin_reg & prev_reg);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      edge_out <= 1'b0;
    end else begin
      edge_out <= edge_next;
    end
  end

endmodule

// File: verilog/free_running_counter.sv
// Purpose: 16-bit free-running upcounter with byte views and overflow
// Assumes: one cpu access strobe per cycle, reads take data next cycle
// Notes:   capture, compare and pwm live elsewhere
// Notes on behaviour
// - sixteen-bit upcounter, free running, wraps
// - value split into high and low bytes
// - count clock: cpu div 2, 4, 8, external
// - software picks active external clock edge
// - low byte write reloads FFFCh
// - reset loads FFFCh; only reload value
// - main and alternate views, same value
// - first high byte read buffers low byte
// - buffered low byte frozen until low read
// - lone low read returns live byte
// - wrap FFFF to 0000 sets overflow flag
// - interrupt needs enable and global unmask
// - flag clears: status read then low access
// - alternate low access never clears flag
// - wait mode leaves counter running
// - halt stops counter, resumes held value
// - instances independent, in step after reset
// - unbonded timer input reads as one
// - both select bits one picks external
// - external counts synced to falling cpu edge
`timescale 1ns/1ps
module free_running_counter
  import frc_pkg::*;
(
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic [1:0]   count_clock_select_in,
  input  wire logic         external_edge_select_in,
  input  wire logic         external_count_clock_pin_in,
  input  wire logic         overflow_interrupt_enable_in,
  input  wire logic         global_unmask_in,
  input  wire logic         halt_in,
  input  wire logic         wait_in,
  input  wire logic         rd_high_in,
  input  wire logic         rd_low_in,
  input  wire logic         wr_low_in,
  input  wire logic         rd_alt_high_in,
  input  wire logic         rd_alt_low_in,
  input  wire logic         wr_alt_low_in,
  input  wire logic         rd_status_in,
  output logic [7:0]        rd_data_out,
  output logic              overflow_flag_out,
  output logic              irq_out,
  output logic [15:0]       count_out
);

  logic [15:0] count_reg;
  logic [2:0]  presc_reg;
  logic [7:0]  low_buf_reg;
  logic        overflow_flag_reg;
  logic        clear_armed_reg;
  read_state_t read_state_reg;
  logic        ext_edge;
  logic        tick;
  logic        reload;
  logic        wrap;
  logic        high_rd;
  logic        low_rd;
  logic        clr_access;

  // all checks below share the cpu clock and the reset
  default clocking chk_cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic presc_tick(input logic [1:0] sel,
                                      input logic [2:0] p);
    case (sel)
      SEL_DIV2: presc_tick = ((p & MASK_DIV2) == MASK_DIV2);
      SEL_DIV4: presc_tick = ((p & MASK_DIV4) == MASK_DIV4);
      SEL_DIV8: presc_tick = ((p & MASK_DIV8) == MASK_DIV8);
      default:  presc_tick = 1'b0;
    endcase
  endfunction

  ext_edge_detect u_edge (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .pin_in    (external_count_clock_pin_in),
    .rising_in (external_edge_select_in),
    .edge_out  (ext_edge)
  );

  assign high_rd    = rd_high_in | rd_alt_high_in;
  assign low_rd     = rd_low_in | rd_alt_low_in;
  assign reload     = wr_low_in | wr_alt_low_in;
  assign clr_access = rd_low_in | wr_low_in;

  // wait_in is deliberately unused by the count path
  always_comb begin
    if (halt_in) begin
      tick = 1'b0;
    end else if (count_clock_select_in == SEL_EXT) begin
      tick = ext_edge;
    end else begin
      tick = presc_tick(count_clock_select_in, presc_reg);
    end
  end

  assign wrap = tick & ~reload & (count_reg == COUNT_MAX);

  // ---------------------------------------------------------------
  // prescaler and counter
  // ---------------------------------------------------------------
  // prescaler shares reset so twin instances stay in step
  // halt freezes it as well, so the count phase survives a halt
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      presc_reg <= 3'h0;
    end else if (!halt_in) begin
      presc_reg <= presc_reg + 3'h1;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      count_reg <= COUNT_RESET;
    end else if (reload) begin
      count_reg <= COUNT_RESET;
    end else if (tick) begin
      count_reg <= count_reg + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // buffered read sequence
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      read_state_reg <= RD_IDLE;
      low_buf_reg    <= 8'h00;
    end else begin
      case (read_state_reg)
        RD_IDLE: begin
          if (high_rd) begin
            low_buf_reg    <= count_reg[7:0];
            read_state_reg <= RD_HELD;
          end
        end
        RD_HELD: begin
          if (low_rd) begin
            read_state_reg <= RD_IDLE;
          end
        end
        default: read_state_reg <= RD_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_data_out <= 8'h00;
    end else if (high_rd) begin
      rd_data_out <= count_reg[15:8];
    end else if (low_rd) begin
      rd_data_out <= (read_state_reg == RD_HELD) ? low_buf_reg
                                                  : count_reg[7:0];
    end else if (rd_status_in) begin
      rd_data_out <= {overflow_flag_reg, 7'h00};
    end
  end

  // ---------------------------------------------------------------
  // overflow flag and interrupt
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      overflow_flag_reg <= 1'b0;
      clear_armed_reg   <= 1'b0;
    end else begin
      if (wrap) begin
        overflow_flag_reg <= 1'b1;
      end else if (clear_armed_reg && clr_access) begin
        overflow_flag_reg <= 1'b0;
      end
      if (rd_status_in && overflow_flag_reg) begin
        clear_armed_reg <= 1'b1;
      end else if (clr_access) begin
        clear_armed_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= overflow_flag_reg & overflow_interrupt_enable_in
                 & global_unmask_in;
    end
  end

  assign overflow_flag_out = overflow_flag_reg;
  assign count_out         = count_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence status_then_clear;
    (rd_status_in && overflow_flag_reg) ##1 (clr_access && !wrap)[*1];
  endsequence

  sequence high_first;
    read_state_reg == RD_IDLE && high_rd;
  endsequence

  sequence div2_pair;
    (!halt_in && count_clock_select_in == SEL_DIV2)[*2];
  endsequence

  // counter
  reload_value_a: assert property (
    reload |=> count_reg == COUNT_RESET)
    else $error("reload did not load FFFC");
  tick_step_a: assert property (
    (tick && !reload) |=> count_reg == $past(count_reg) + 16'h0001)
    else $error("counter did not step by one");
  idle_hold_a: assert property (
    (!tick && !reload) |=> $stable(count_reg))
    else $error("counter moved without a tick");
  halt_freeze_a: assert property (
    (halt_in && !reload) |=> $stable(count_reg))
    else $error("counter moved in halt");
  halt_presc_a: assert property (
    halt_in |=> $stable(presc_reg))
    else $error("prescaler moved in halt");
  wait_runs_a: assert property (
    wait_in ##0 div2_pair |-> tick || $past(tick))
    else $error("counter stalled in wait");
  div4_rate_a: assert property (
    (count_clock_select_in == SEL_DIV4 && tick)
    |=> (!tick || count_clock_select_in != SEL_DIV4)[*3])
    else $error("div4 ticked too often");
  div8_rate_a: assert property (
    (count_clock_select_in == SEL_DIV8 && !halt_in && tick && !reload)
    |=> (!tick || count_clock_select_in != SEL_DIV8)[*7])
    else $error("div8 ticked too often");
  ext_select_a: assert property (
    (count_clock_select_in == SEL_EXT && !halt_in) |-> tick == ext_edge)
    else $error("external select ignored pin edge");

  // read sequence
  high_capture_a: assert property (
    high_first |=> read_state_reg == RD_HELD
                   && low_buf_reg == $past(count_reg[7:0]))
    else $error("high read did not buffer low byte");
  high_data_a: assert property (
    high_rd |=> rd_data_out == $past(count_reg[15:8]))
    else $error("high byte read data wrong");
  buf_frozen_a: assert property (
    (read_state_reg == RD_HELD && !low_rd) |=> $stable(low_buf_reg))
    else $error("buffered low byte changed");
  held_low_a: assert property (
    (read_state_reg == RD_HELD && low_rd && !high_rd)
    |=> rd_data_out == $past(low_buf_reg) && read_state_reg == RD_IDLE)
    else $error("held low read returned wrong byte");
  live_low_a: assert property (
    (read_state_reg == RD_IDLE && low_rd && !high_rd)
    |=> rd_data_out == $past(count_reg[7:0]))
    else $error("lone low read not live");

  // overflow flag and interrupt
  wrap_sets_a: assert property (
    wrap |=> overflow_flag_reg && count_reg == 16'h0000)
    else $error("wrap did not set overflow");
  flag_source_a: assert property (
    (!overflow_flag_reg && !wrap) |=> !overflow_flag_reg)
    else $error("flag set without a wrap");
  arm_on_status_a: assert property (
    (rd_status_in && overflow_flag_reg) |=> clear_armed_reg)
    else $error("status read did not arm clear");
  clear_needs_arm_a: assert property (
    (overflow_flag_reg && !clear_armed_reg) |=> overflow_flag_reg)
    else $error("flag cleared without status read");
  two_step_clear_a: assert property (
    status_then_clear |=> !overflow_flag_reg)
    else $error("two step clear failed");
  status_byte_a: assert property (
    (rd_status_in && !high_rd && !low_rd)
    |=> rd_data_out == {$past(overflow_flag_reg), 7'h00})
    else $error("status byte wrong");
  alt_keeps_flag_a: assert property (
    (overflow_flag_reg && !clr_access) |=> overflow_flag_reg)
    else $error("flag cleared without low access");
  set_wins_a: assert property (
    (wrap && clr_access) |=> overflow_flag_reg)
    else $error("clear beat overflow set");
  irq_gate_a: assert property (
    irq_out |-> $past(overflow_interrupt_enable_in)
                && $past(global_unmask_in))
    else $error("irq without enable");
  irq_pending_a: assert property (
    (overflow_flag_reg && overflow_interrupt_enable_in && global_unmask_in)
    |=> irq_out)
    else $error("pending overflow not requested");

endmodule

// File: dv/ext_clock_source.sv
// Purpose: external count clock source facing the timer counter pin
// Assumes: runs from the cpu clock of the bench
// Notes:   idles high between bursts, like an unbonded pin
`timescale 1ns/1ps
module ext_clock_source (
  input  wire logic       clk_in,
  input  wire logic       go_in,
  input  wire logic [7:0] pulses_in,
  output logic            pin_out,
  output logic            busy_out
);
  logic [7:0] left_reg;
  logic [2:0] ph_reg;

  initial begin
    pin_out = 1'b1;
    busy_out = 1'b0;
  end

  // four cpu clocks between edges, eight between active edges: twice the minimum spacing
  always @(posedge clk_in) begin
    if (!busy_out) begin
      pin_out <= 1'b1;
      busy_out <= go_in && (pulses_in != 8'h00);
      left_reg <= pulses_in;
      ph_reg <= 3'h0;
    end else begin
      pin_out <= ph_reg[2];
      ph_reg <= ph_reg + 3'h1;
      if (ph_reg == 3'h7) begin
        left_reg <= left_reg - 8'h01;
        busy_out <= (left_reg != 8'h01);
      end
    end
  end
endmodule

// File: dv/testbench.sv
// Purpose: self-checking bench for the free running counter
// Assumes: one access strobe at a time, read data a cycle later
// Notes:   counts are checked over whole prescaler periods
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin bad_count++; \
  $display("CHECK FAILED t=%0t got %0h exp %0h", $time, a, b); end end
module testbench;
  import frc_pkg::*;
  localparam int RH = 0, RL = 1, WL = 2, AH = 3, AL = 4, WA = 5, ST = 6;
  logic        clk_in, rst_in, edge_sel, ie, um, halt, wt, go, flag, irq;
  logic        pin, busy;
  logic [1:0]  sel;
  logic [6:0]  stb;
  logic [7:0]  np, rd_data, d;
  logic [15:0] cnt, c, c0;
  int          bad_count, tests_run, cyc, k, i;

  free_running_counter u_free_running_counter (
    .clk_in(clk_in), .rst_in(rst_in), .count_clock_select_in(sel),
    .external_edge_select_in(edge_sel), .external_count_clock_pin_in(pin),
    .overflow_interrupt_enable_in(ie), .global_unmask_in(um),
    .halt_in(halt), .wait_in(wt), .rd_high_in(stb[RH]),
    .rd_low_in(stb[RL]), .wr_low_in(stb[WL]), .rd_alt_high_in(stb[AH]),
    .rd_alt_low_in(stb[AL]), .wr_alt_low_in(stb[WA]),
    .rd_status_in(stb[ST]), .rd_data_out(rd_data),
    .overflow_flag_out(flag), .irq_out(irq), .count_out(cnt));
  ext_clock_source u_ext_clock_source (.clk_in(clk_in), .go_in(go),
    .pulses_in(np), .pin_out(pin), .busy_out(busy));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // count is sampled the half cycle before the edge that takes the strobe
  task automatic acc(input int w, output logic [7:0] dv,
                     output logic [15:0] cv);
    @(posedge clk_in);
    stb <= 7'h01 << w;
    @(negedge clk_in);
    cv = cnt;
    @(posedge clk_in);
    stb <= 7'h00;
    @(negedge clk_in);
    dv = rd_data;
  endtask

  task automatic rate(input logic [1:0] s, input int div);
    @(posedge clk_in);
    sel <= s;
    repeat (4) @(negedge clk_in);
    c0 = cnt;
    repeat (8 * div) @(negedge clk_in);
    `CHK(cnt - c0, 16'h0008)
  endtask

  // ----------------------------------------------------------------
  // clock, timeout and main sequence
  // ----------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end

  initial begin
    void'($urandom(45));
    {rst_in, sel, edge_sel, ie, um, halt, wt, go} = {1'b1, SEL_DIV2, 6'h00};
    {stb, np, bad_count, tests_run, cyc} = '0;
    repeat (8) @(posedge clk_in);
    `CHK(cnt, COUNT_RESET)
    `CHK(flag, 1'b0)
    rst_in <= 1'b0;
    rate(SEL_DIV2, 2);
    rate(SEL_DIV4, 4);
    rate(SEL_DIV8, 8);
    @(posedge clk_in);
    wt <= 1'b1;
    rate(SEL_DIV2, 2);
    for (k = 0; k < 2; k++) begin
      repeat ($urandom_range(30, 3)) @(posedge clk_in);
      acc(k ? WA : WL, d, c);
      `CHK(cnt, COUNT_RESET)
      acc(k ? AH : RH, d, c);
      `CHK(d, c[15:8])
      c0 = c;
      repeat ($urandom_range(20, 5)) @(posedge clk_in);
      acc(k ? AH : RH, d, c);
      acc(k ? AL : RL, d, c);
      `CHK(d, c0[7:0])
      acc(k ? AL : RL, d, c);
      `CHK(d, c[7:0])
    end
    @(posedge clk_in);
    ie <= 1'b1;
    // flag is still set from the wraps above: clear it before waiting
    acc(ST, d, c);
    `CHK(d[7], 1'b1)
    acc(WL, d, c);
    `CHK(flag, 1'b0)
    for (i = 0; i < 40 && flag !== 1'b1; i++) @(negedge clk_in);
    `CHK(cnt, 16'h0000)
    `CHK(flag, 1'b1)
    repeat (3) @(negedge clk_in);
    `CHK(irq, 1'b0)
    @(posedge clk_in);
    um <= 1'b1;
    repeat (2) @(negedge clk_in);
    `CHK(irq, 1'b1)
    @(posedge clk_in);
    {ie, halt} <= 2'h1;
    repeat (2) @(negedge clk_in);
    `CHK(irq, 1'b0)
    c0 = cnt;
    acc(RL, d, c);
    `CHK(flag, 1'b1)
    acc(ST, d, c);
    `CHK(d[7], 1'b1)
    acc(AL, d, c);
    `CHK(flag, 1'b1)
    acc(RL, d, c);
    `CHK(flag, 1'b0)
    `CHK(cnt, c0)
    @(posedge clk_in);
    halt <= 1'b0;
    // eight running edges span whole div2 periods, whatever the phase
    repeat (9) @(negedge clk_in);
    `CHK(cnt - c0, 16'h0004)
    @(posedge clk_in);
    {rst_in, halt} <= 2'h3;
    repeat (2) @(negedge clk_in);
    `CHK(cnt, COUNT_RESET)
    @(posedge clk_in);
    {rst_in, halt} <= 2'h0;
    @(posedge clk_in);
    sel <= SEL_EXT;
    for (k = 0; k < 2; k++) begin
      @(posedge clk_in);
      {edge_sel, go, np} <= {k[0], 1'b1, 8'($urandom_range(9, 2))};
      @(negedge clk_in);
      c0 = cnt;
      @(posedge clk_in);
      go <= 1'b0;
      repeat (2) @(negedge clk_in);
      for (i = 0; i < 200 && busy !== 1'b0; i++) @(negedge clk_in);
      repeat (6) @(negedge clk_in);
      `CHK(cnt - c0, {8'h00, np})
    end
    report_and_stop();
  end
endmodule
